// *** abd_core.sv ***
// decode/execute block for add-with-carry, and, bit-clear and flag branches
// assumes a same-clock instruction source and a data memory that answers
// a read within the cycle in which the address is shown (combinational read)
//
// Operation
// - add-with-carry-to-file sums accumulator, file register and carry and sets N, OV, C, DC and Z.
// - a byte-oriented file result goes to the accumulator when the destination bit is 0, else to the file.
// - bank bit 0 selects the access bank, bank bit 1 forms the address from the bank select pointer.
// - with the extended set on, bank bit 0 and operand at most 5Fh use index-plus-offset addressing.
// - and-with-literal puts accumulator AND literal in the accumulator and changes only N and Z.
// - and-with-file ANDs accumulator and file register and stores by the destination bit.
// - branch-on-carry-set branches only when carry is 1 and leaves flags alone.
// - branch-on-negative branches only when negative is 1 and leaves flags alone.
// - branch-on-carry-clear branches only when carry is 0 and leaves flags alone.
// - a taken branch loads the incremented counter plus twice the signed 8-bit offset.
// - a taken branch takes two cycles with an all-idle second one; an untaken one writes nothing in Q4.

`timescale 1ns/10ps

module abd_core #(
  parameter int PC_WIDTH = 21
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  // instruction stream
  input  wire logic                 instrValid,
  output logic                      instrReady,
  input  wire logic [15:0]          instrWord,
  // data memory
  output abd_pkg::abd_mem_t         memReq,
  input  wire logic [7:0]           memRdData,
  // axi4-lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import abd_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  function automatic abd_instr_t decodeInstr(input logic [15:0] w);
    abd_instr_t d;
    d.op      = OP_NOP;
    d.toFile  = w[9];
    d.bankBit = w[8];
    d.bitIdx  = w[11:9];
    d.operand = w[7:0];
    if (w[15:10] == OPC_ADD_CARRY)
      d.op = OP_ADD_CARRY;
    else if (w[15:10] == OPC_AND_FILE)
      d.op = OP_AND_FILE;
    else if (w[15:8] == OPC_AND_LIT)
      d.op = OP_AND_LIT;
    else if (w[15:8] == OPC_BR_CSET)
      d.op = OP_BR_CSET;
    else if (w[15:8] == OPC_BR_CCLR)
      d.op = OP_BR_CCLR;
    else if (w[15:8] == OPC_BR_NEG)
      d.op = OP_BR_NEG;
    else if (w[15:12] == OPC_CLR_BIT)
      d.op = OP_CLR_BIT;
    return d;
  endfunction

  // file address from bank bit, operand and mode
  function automatic logic [11:0] formAddr(input logic bankBit, input logic [7:0] f,
                                           input logic extOn, input logic [3:0] bank,
                                           input logic [11:0] index);
    logic [11:0] a;
    a = {bank, f};
    if (!bankBit)
    begin
      if (extOn && (f <= ACCESS_LOW_LAST))
        a = index + {4'h0, f};
      else if (f <= ACCESS_LOW_LAST)
        a = {4'h0, f};
      else
        a = {ACCESS_HIGH_BANK, f};
    end
    return a;
  endfunction

  function automatic logic usesFile(input abd_op_t op);
    return (op == OP_ADD_CARRY) || (op == OP_AND_FILE) || (op == OP_CLR_BIT);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  abd_phase_t            phase_q;
  abd_instr_t            cur_q;
  logic                  idleCycle_q;   // second cycle of a taken branch
  logic [1:0]            ctrl_q;
  logic [7:0]            accum_q;
  logic [4:0]            status_q;
  logic [3:0]            bankSel_q;
  logic [11:0]           index_q;
  logic [PC_WIDTH-1:0]   pc_q;
  logic [15:0]           lastOp_q;
  logic [7:0]            fileVal_q;
  logic [7:0]            result_q;
  logic [4:0]            flags_q;
  logic                  taken_q;
  abd_mem_t              mem_q;

  logic [7:0]            result_d;
  logic [4:0]            flags_d;
  logic                  taken_d;
  logic                  accepted;
  logic                  commit;
  abd_instr_t            dec;

  // axi slave state
  logic                  awHave_q;
  logic                  wHave_q;
  logic [7:0]            awAddr_q;
  logic [31:0]           wData_q;
  logic [3:0]            wStrb_q;
  logic                  swWrite;
  logic [31:0]           rdata_d;
  logic                  rdHit;

  // ----------------------------------------------------------------
  // phase sequencing and instruction intake
  // ----------------------------------------------------------------

  // phases rotate every clock; one instruction per four clocks
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      phase_q <= PH_Q1;
    else
    begin
      unique case (phase_q)
        PH_Q1: phase_q <= PH_Q2;
        PH_Q2: phase_q <= PH_Q3;
        PH_Q3: phase_q <= PH_Q4;
        PH_Q4: phase_q <= PH_Q1;
      endcase
    end
  end

  // intake only in Q1, never during the idle second cycle of a jump
  assign instrReady = (phase_q == PH_Q1) && !idleCycle_q && ctrl_q[CTRL_RUN_BIT];
  assign accepted   = instrReady && instrValid;
  assign dec        = decodeInstr(instrWord);
  assign commit     = (phase_q == PH_Q4) && !idleCycle_q;

  // latch decoded word; an empty Q1 runs as a no-operation cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cur_q    <= '0;
      lastOp_q <= 16'h0000;
    end
    else if (phase_q == PH_Q1)
    begin
      if (accepted)
      begin
        cur_q    <= dec;
        lastOp_q <= instrWord;
      end
      else
        cur_q <= '0;
    end
  end

  // taken branch: next cycle is four idle phases
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      idleCycle_q <= 1'b0;
    else if (phase_q == PH_Q4)
      idleCycle_q <= !idleCycle_q && taken_q;
  end

  // ----------------------------------------------------------------
  // datapath: Q2 read, Q3 process, Q4 write
  // ----------------------------------------------------------------

  // file operand captured at end of Q2 (address shown from Q2 on)
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      fileVal_q <= 8'h00;
    else if (phase_q == PH_Q2)
      fileVal_q <= memRdData;
  end

  // arithmetic and branch decision
  always_comb
  begin
    logic [8:0] sum9;
    logic [4:0] lowSum;
    sum9     = '0;
    lowSum   = '0;
    result_d = accum_q;
    flags_d  = status_q;
    taken_d  = 1'b0;
    unique case (cur_q.op)
      OP_ADD_CARRY:
      begin
        sum9   = {1'b0, accum_q} + {1'b0, fileVal_q} + {8'h00, status_q[FLAG_C]};
        lowSum = {1'b0, accum_q[3:0]} + {1'b0, fileVal_q[3:0]} + {4'h0, status_q[FLAG_C]};
        result_d         = sum9[7:0];
        flags_d[FLAG_C]  = sum9[8];
        flags_d[FLAG_DC] = lowSum[4];
        flags_d[FLAG_OV] = (accum_q[7] == fileVal_q[7]) && (sum9[7] != accum_q[7]);
        flags_d[FLAG_N]  = sum9[7];
        flags_d[FLAG_Z]  = (sum9[7:0] == 8'h00);
      end
      OP_AND_LIT, OP_AND_FILE:
      begin
        // only N and Z move for the logical ops
        result_d = accum_q & ((cur_q.op == OP_AND_LIT) ? cur_q.operand : fileVal_q);
        flags_d[FLAG_N] = result_d[7];
        flags_d[FLAG_Z] = (result_d == 8'h00);
      end
      OP_CLR_BIT:
      begin
        result_d = fileVal_q & ~(8'h01 << cur_q.bitIdx);
      end
      OP_BR_CSET: taken_d = status_q[FLAG_C];
      OP_BR_CCLR: taken_d = !status_q[FLAG_C];
      OP_BR_NEG:  taken_d = status_q[FLAG_N];
      OP_NOP:     taken_d = 1'b0;
      default:    taken_d = 1'b0;                   // reached only by an X or Z op; all eight encodings are named
    endcase
  end

  // process stage registers, loaded at end of Q3
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      result_q <= 8'h00;
      flags_q  <= STATUS_RESET;
      taken_q  <= 1'b0;
    end
    else if (phase_q == PH_Q3)
    begin
      result_q <= result_d;
      flags_q  <= flags_d;
      taken_q  <= taken_d;
    end
    else if (phase_q == PH_Q4)
      taken_q <= 1'b0;
  end

  // memory port: address from Q2, write strobe through Q4 only
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      mem_q <= '0;
    else if (phase_q == PH_Q1)
    begin
      mem_q.addr <= formAddr(dec.bankBit, dec.operand, ctrl_q[CTRL_EXT_BIT], bankSel_q, index_q);
      mem_q.wrEn <= 1'b0;
    end
    else if (phase_q == PH_Q3)
    begin
      // clear-bit always writes back; byte ops only with destination 1
      mem_q.wrEn   <= usesFile(cur_q.op) && (cur_q.toFile || cur_q.op == OP_CLR_BIT);
      mem_q.wrData <= result_d;
    end
    else if (phase_q == PH_Q4)
      mem_q.wrEn <= 1'b0;
  end
  assign memReq = mem_q;

  // ----------------------------------------------------------------
  // architectural registers (core commit outranks software write)
  // ----------------------------------------------------------------

  // accumulator
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      accum_q <= ACCUM_RESET;
    else if (commit && (cur_q.op == OP_AND_LIT ||
             ((cur_q.op == OP_ADD_CARRY || cur_q.op == OP_AND_FILE) && !cur_q.toFile)))
      accum_q <= result_q;
    else if (swWrite && awAddr_q == ADDR_ACCUM && wStrb_q[0])
      accum_q <= wData_q[7:0];
  end

  // status flags; only flag-setting ops commit, so idle cycles never undo a software write
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      status_q <= STATUS_RESET;
    else if (commit && (cur_q.op == OP_ADD_CARRY || cur_q.op == OP_AND_LIT || cur_q.op == OP_AND_FILE))
      status_q <= flags_q;
    else if (swWrite && awAddr_q == ADDR_STATUS && wStrb_q[0])
      status_q <= wData_q[4:0];
  end

  // program counter: +2 at intake, offset added in Q4 of a taken branch
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pc_q <= '0;
    else if (accepted)
      pc_q <= pc_q + PC_WIDTH'(PC_STEP);
    else if (commit && taken_q)
      pc_q <= pc_q + PC_WIDTH'({{(PC_WIDTH-9){cur_q.operand[7]}}, cur_q.operand, 1'b0});
    else if (swWrite && awAddr_q == ADDR_PC)
      pc_q <= wData_q[PC_WIDTH-1:0];
  end

  // software-only control registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q    <= CTRL_RESET;
      bankSel_q <= BANKSEL_RESET;
      index_q   <= INDEX_RESET;
    end
    else if (swWrite)
    begin
      if (awAddr_q == ADDR_CTRL && wStrb_q[0])
        ctrl_q <= wData_q[1:0];
      if (awAddr_q == ADDR_BANKSEL && wStrb_q[0])
        bankSel_q <= wData_q[3:0];
      if (awAddr_q == ADDR_INDEX)
        index_q <= wData_q[11:0];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------

  // address and data held separately, taken in either order
  assign s_axi_awready = !awHave_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHave_q && !s_axi_bvalid;
  assign swWrite       = awHave_q && wHave_q && !s_axi_bvalid;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      awHave_q     <= 1'b0;
      wHave_q      <= 1'b0;
      awAddr_q     <= 8'h00;
      wData_q      <= 32'h0000_0000;
      wStrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_q <= 1'b1;
        awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (swWrite)
      begin
        // the last-opcode register is read only and answers slverr
        awHave_q     <= 1'b0;
        wHave_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_q <= ADDR_PC) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read mux
  always_comb
  begin
    rdHit   = 1'b1;
    rdata_d = 32'h0000_0000;
    unique case ({s_axi_araddr[7:2], 2'b00})
      ADDR_CTRL:    rdata_d[1:0]          = ctrl_q;
      ADDR_ACCUM:   rdata_d[7:0]          = accum_q;
      ADDR_STATUS:  rdata_d[4:0]          = status_q;
      ADDR_BANKSEL: rdata_d[3:0]          = bankSel_q;
      ADDR_INDEX:   rdata_d[11:0]         = index_q;
      ADDR_PC:      rdata_d[PC_WIDTH-1:0] = pc_q;
      ADDR_LASTOP:  rdata_d[15:0]         = lastOp_q;
      default:      rdHit                 = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_d;
      s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // abd_core

// *** abd_pkg.sv ***
// package for the accumulator/branch decode-execute block
// assumes a single 125 MHz clock and an AXI4-Lite master on the register side

package abd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_ACCUM   = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_BANKSEL = 8'h0C;
  localparam logic [7:0] ADDR_INDEX   = 8'h10;
  localparam logic [7:0] ADDR_PC      = 8'h14;
  localparam logic [7:0] ADDR_LASTOP  = 8'h18;

  // ctrl fields and reset values
  localparam int          CTRL_EXT_BIT   = 0;
  localparam int          CTRL_RUN_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam logic [7:0]  ACCUM_RESET    = 8'h00;
  localparam logic [4:0]  STATUS_RESET   = 5'h00;
  localparam logic [3:0]  BANKSEL_RESET  = 4'h0;
  localparam logic [11:0] INDEX_RESET    = 12'h000;

  // status flag positions
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N  = 4;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // opcode fields
  localparam logic [5:0] OPC_ADD_CARRY = 6'h08;  // 0010 00da
  localparam logic [5:0] OPC_AND_FILE  = 6'h05;  // 0001 01da
  localparam logic [7:0] OPC_AND_LIT   = 8'h0B;  // 0000 1011
  localparam logic [7:0] OPC_BR_CSET   = 8'hE2;
  localparam logic [7:0] OPC_BR_CCLR   = 8'hE3;
  localparam logic [7:0] OPC_BR_NEG    = 8'hE6;
  localparam logic [3:0] OPC_CLR_BIT   = 4'h9;

  // addressing constants
  localparam logic [7:0] ACCESS_LOW_LAST  = 8'h5F;  // also the indexed-mode limit
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam int         PC_STEP          = 2;

  // quarter phases of one instruction cycle
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } abd_phase_t;

  typedef enum logic [2:0] {
    OP_NOP, OP_ADD_CARRY, OP_AND_LIT, OP_AND_FILE, OP_BR_CSET, OP_BR_CCLR, OP_BR_NEG, OP_CLR_BIT
  } abd_op_t;

  typedef struct packed {
    abd_op_t    op;
    logic       toFile;
    logic       bankBit;
    logic [2:0] bitIdx;
    logic [7:0] operand;
  } abd_instr_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        wrEn;
    logic [7:0]  wrData;
  } abd_mem_t;

endpackage

// *** abd_core_chk.sv ***
// checker for the accumulator/branch decode-execute block
// assumes it is bound to abd_core and sees only its ports

`timescale 1ns/10ps

module abd_core_chk
  import abd_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        instrValid,
  input wire logic        instrReady,
  input wire logic [15:0] instrWord,
  input abd_mem_t         memReq,
  input wire logic [7:0]  memRdData,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // fileOp: every opcode here that touches a file register
  wire logic       take   = instrValid && instrReady;
  wire logic       isClr  = instrWord[15:12] == 4'h9;
  wire logic       fileOp = instrWord[15:10] == 6'h08 || instrWord[15:10] == 6'h05 || isClr;
  wire logic [7:0] fOp    = instrWord[7:0];
  wire logic [2:0] bIdx   = instrWord[11:9];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  ready_spacing_a: assert property (take |=> !instrReady [*3])
    else $error("instruction accepted twice within one cycle");
  one_cycle_a: assert property (take && instrWord[15:12] != 4'hE |=> !instrReady [*3] ##1 instrReady)
    else $error("non-branch instruction did not finish in one cycle");
  branch_quiet_a: assert property (take && instrWord[15:12] == 4'hE |=> !memReq.wrEn [*6])
    else $error("branch wrote data memory");
  lit_nowrite_a: assert property (take && instrWord[15:8] == 8'h0B |=> !memReq.wrEn [*4])
    else $error("literal and wrote data memory");
  dest_file_a: assert property (take && fileOp && (isClr || instrWord[9]) |-> ##3 memReq.wrEn)
    else $error("file destination not written in Q4");
  dest_accum_a: assert property (take && fileOp && !isClr && !instrWord[9] |=> !memReq.wrEn [*4])
    else $error("accumulator destination wrote a file register");
  access_high_a: assert property (take && fileOp && !instrWord[8] && fOp > 8'h5F
                                  |=> memReq.addr == {4'hF, $past(fOp)})
    else $error("access bank upper half address wrong");
  bank_low_a: assert property (take && fileOp && instrWord[8] |=> memReq.addr[7:0] == $past(fOp))
    else $error("banked address low byte wrong");
  bit_clear_a: assert property (take && isClr |-> ##3 memReq.wrEn && !memReq.wrData[$past(bIdx, 3)])
    else $error("selected bit not cleared");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not valid one edge after address taken");
  write_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response still valid after it was taken");
endmodule // abd_core_chk

// *** abd_core_test.sv ***
// self-checking bench for the accumulator/branch decode-execute block
// assumes abd_core and abd_core_chk are compiled; the bench models data memory

`timescale 1ns/10ps

module abd_core_test;
  import abd_pkg::*;
  logic        clock = 1'b0, rst = 1'b1, instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic        instrReady;
  abd_mem_t    memReq;
  logic [7:0]  memRdData;
  logic [7:0]  mem [0:4095];
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          errorCnt = 0, checks = 0, wrCnt = 0, cyc = 0;

  abd_core uut (.clock(clock), .rst(rst), .instrValid(instrValid), .instrReady(instrReady),
    .instrWord(instrWord), .memReq(memReq), .memRdData(memRdData), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  // ----------------------------------------------------------------
  // clock, memory model, watchdog
  // ----------------------------------------------------------------
  // 125 MHz
  always #4 clock = ~clock;
  // combinational read, write on the Q4 pulse
  assign memRdData = mem[memReq.addr];
  always @(posedge clock)
  begin
    if (memReq.wrEn === 1'b1)
    begin
      mem[memReq.addr] <= memReq.wrData;
      wrCnt <= wrCnt + 1;
    end
  end
  // the whole run needs a few hundred cycles; the ceiling leaves ample margin
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errorCnt++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge clock);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clock);
      if (!aw && s_axi_awready) begin aw = 1; s_axi_awvalid <= 1'b0; end
      if (!w && s_axi_wready) begin w = 1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask

  task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge clock);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    axr(a, RESP_OKAY, d);
    chk(nm, d, exp);
  endtask

  // leaves instrValid high so a following word goes back to back
  task automatic issue(input logic [15:0] w, output int n);
    instrValid <= 1'b1;
    instrWord <= w;
    n = 0;
    do begin @(posedge clock); n++; end while (instrReady !== 1'b1);
  endtask

  task automatic run1(input logic [15:0] w);
    int n;
    issue(w, n);
    instrValid <= 1'b0;
    repeat (8) @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    rdchk(ADDR_CTRL, 32'(CTRL_RESET), "ctrl");
    rdchk(ADDR_STATUS, 32'(STATUS_RESET), "status");
    rdchk(ADDR_INDEX, 32'(INDEX_RESET), "index");
    axr(8'h1C, RESP_SLVERR, d);
    axw(ADDR_LASTOP, 32'h0, RESP_SLVERR);
  endtask

  task automatic t_add();
    axw(ADDR_CTRL, 32'h2, RESP_OKAY);
    axw(ADDR_BANKSEL, 32'h2, RESP_OKAY);
    axw(ADDR_ACCUM, 32'h4D, RESP_OKAY);
    axw(ADDR_STATUS, 32'h01, RESP_OKAY);
    mem[12'h210] = 8'h02;
    run1(16'h2110);
    rdchk(ADDR_ACCUM, 32'h50, "add accum");
    rdchk(ADDR_STATUS, 32'h02, "add flags");
    chk("add file kept", 32'(mem[12'h210]), 32'h02);
    axw(ADDR_ACCUM, 32'h80, RESP_OKAY);
    axw(ADDR_STATUS, 32'h00, RESP_OKAY);
    mem[12'hF60] = 8'h80;
    run1(16'h2260);
    chk("add to file", 32'(mem[12'hF60]), 32'h00);
    rdchk(ADDR_ACCUM, 32'h80, "add accum kept");
    rdchk(ADDR_STATUS, 32'h0D, "add carry flags");
    mem[12'h040] = 8'h7F;
    run1(16'h2240);
    chk("add access low", 32'(mem[12'h040]), 32'h00);
    rdchk(ADDR_STATUS, 32'h07, "add low flags");
  endtask

  task automatic t_and();
    axw(ADDR_ACCUM, 32'hA3, RESP_OKAY);
    axw(ADDR_STATUS, 32'h0B, RESP_OKAY);
    run1(16'h0B5F);
    rdchk(ADDR_ACCUM, 32'h03, "andlit accum");
    rdchk(ADDR_STATUS, 32'h0B, "andlit flags");
    run1(16'h0B00);
    rdchk(ADDR_STATUS, 32'h0F, "andlit zero");
    axw(ADDR_CTRL, 32'h3, RESP_OKAY);
    axw(ADDR_INDEX, 32'h300, RESP_OKAY);
    axw(ADDR_ACCUM, 32'h97, RESP_OKAY);
    mem[12'h305] = 8'hC2;
    run1(16'h1605);
    chk("andfile indexed", 32'(mem[12'h305]), 32'h82);
    rdchk(ADDR_STATUS, 32'h1B, "andfile flags");
    mem[12'h220] = 8'hC7;
    run1(16'h9F20);
    chk("bit clear", 32'(mem[12'h220]), 32'h47);
    rdchk(ADDR_STATUS, 32'h1B, "bit clear flags");
  endtask

  task automatic t_branch();
    logic [4:0]  st [6] = '{5'h01, 5'h1E, 5'h10, 5'h01, 5'h10, 5'h0F};
    logic [15:0] op [6] = '{16'hE205, 16'hE205, 16'hE37F, 16'hE37F, 16'hE680, 16'hE680};
    logic [15:0] pc [6] = '{16'h100C, 16'h1002, 16'h1100, 16'h1002, 16'h0F02, 16'h1002};
    int n, w0;
    for (int i = 0; i < 6; i++)
    begin
      axw(ADDR_STATUS, 32'(st[i]), RESP_OKAY);
      axw(ADDR_PC, 32'h1000, RESP_OKAY);
      w0 = wrCnt;
      issue(op[i], n);
      issue(16'h0000, n);
      instrValid <= 1'b0;
      repeat (8) @(posedge clock);
      chk("branch length", 32'(n), (pc[i] != 16'h1002) ? 32'd8 : 32'd4);
      rdchk(ADDR_PC, 32'(pc[i]) + 32'h2, "branch pc");
      rdchk(ADDR_STATUS, 32'(st[i]), "branch flags");
      chk("branch writes", 32'(wrCnt - w0), 32'h0);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'h00;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_add();
    t_and();
    t_branch();
    close_out();
  end
endmodule // abd_core_test

bind abd_core abd_core_chk chk (.clock(clock), .rst(rst), .instrValid(instrValid), .instrReady(instrReady),
  .instrWord(instrWord), .memReq(memReq), .memRdData(memRdData), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
